// ==== rtl/tic_defs.vh ====
// constants for the training information block codec
// included by every design file of the codec; definitions only
`ifndef TIC_DEFS_VH
`define TIC_DEFS_VH

// register offsets on the control bus (byte addresses)
`define TIC_A_CTRL     8'h00
`define TIC_A_TXMSG    8'h04
`define TIC_A_TXSET    8'h08
`define TIC_A_VEND     8'h0c
`define TIC_A_STAT     8'h10
`define TIC_A_RXHDR    8'h14
`define TIC_A_RXINFO   8'h18
`define TIC_A_RXVEND   8'h1c
`define TIC_A_COEF_TAG 2'b01

// control register bits
`define TIC_C_EN       0
`define TIC_C_LEADER   1
`define TIC_C_VEND     2
`define TIC_C_LOCOK    3
`define TIC_C_RESTART  4
`define TIC_C_NEXTGRP  5

// status register sticky bits
`define TIC_S_REFUSED  8
`define TIC_S_CRCERR   9
`define TIC_S_IGNORED  10
`define TIC_S_RXNEW    11

// block layout, bit indices in serial order
`define TIC_SFD        32'h0000a7bb
`define TIC_LAST_BIT   7'd127
`define TIC_CRC_FIRST  7'd32
`define TIC_CRC_LAST   7'd111
`define TIC_CRC_OUT    7'd112
`define TIC_CRC_POLY   16'h8005
`define TIC_ST_BACKOFF 2'b01
`define TIC_OCT_RSVD   8'hf0
`define TIC_MARGIN_UNKNOWN 4'h0

// bus responses
`define TIC_RESP_OK    2'b00
`define TIC_RESP_ERR   2'b10

`endif

// ==== rtl/tic_crc16.v ====
// serial crc16 engine, generator x^16+x^15+x^2+1
// one bit per cycle; clear wins over accumulate and shift-out
`timescale 1ns/1ns
`default_nettype none
`include "tic_defs.vh"

module tic_crc16 (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        clr,
  input  wire        gen,
  input  wire        shift,
  input  wire        din,
  output wire        msb
);

  reg  [15:0] s_reg;
  wire        fb;

  assign fb  = din ^ s_reg[15];
  assign msb = s_reg[15];

  always @(posedge aclk) begin
    if (!aresetn || clr) begin
      s_reg <= 16'h0000;
    end else if (gen) begin
      s_reg <= {s_reg[14:0], 1'b0} ^ (fb ? `TIC_CRC_POLY : 16'h0000);
    end else if (shift) begin
      s_reg <= {s_reg[14:0], 1'b0};
    end
  end

endmodule
`default_nettype wire

// ==== rtl/tic_msg_check.v ====
// checks a message octet against the permitted ordered list of a role
// finds the earliest matching row at or after the previous row
`timescale 1ns/1ns
`default_nettype none
`include "tic_defs.vh"

module tic_msg_check (
  input  wire       leader,
  input  wire [7:0] msg,
  input  wire [3:0] prev_rank,
  output reg        permitted,
  output reg  [3:0] rank
);

  // row: {valid, need_loc, mask[6:0], value[6:0]} over {state, b4, b3..b0}
  function [15:0] row_pat(input ldr, input [3:0] idx);
    begin
      case ({ldr, idx})
        5'h10: row_pat = {2'b10, 7'h7f, 7'b00_0_0000};
        5'h11: row_pat = {2'b10, 7'h7f, 7'b00_1_0000};
        5'h12: row_pat = {2'b10, 7'h7f, 7'b01_1_0000};
        5'h13: row_pat = {2'b10, 7'h7f, 7'b01_1_1000};
        5'h14: row_pat = {2'b10, 7'h7f, 7'b10_1_0000};
        5'h15: row_pat = {2'b10, 7'h7f, 7'b10_1_0100};
        5'h16: row_pat = {2'b10, 7'h7f, 7'b10_1_0000};
        5'h17: row_pat = {2'b10, 7'h7f, 7'b10_1_0010};
        5'h18: row_pat = {2'b10, 7'h7f, 7'b11_1_0000};
        5'h19: row_pat = {2'b11, 7'h7f, 7'b11_1_0001};
        5'h00: row_pat = {2'b10, 7'h7f, 7'b00_0_0000};
        5'h01: row_pat = {2'b10, 7'h6f, 7'b00_0_0000};
        5'h02: row_pat = {2'b10, 7'h7f, 7'b01_1_0000};
        5'h03: row_pat = {2'b10, 7'h7f, 7'b01_1_1000};
        5'h04: row_pat = {2'b10, 7'h6f, 7'b10_0_0000};
        5'h05: row_pat = {2'b10, 7'h7f, 7'b10_1_0100};
        5'h06: row_pat = {2'b10, 7'h7f, 7'b10_1_0000};
        5'h07: row_pat = {2'b10, 7'h7f, 7'b10_1_0010};
        5'h08: row_pat = {2'b10, 7'h6f, 7'b11_0_0000};
        5'h09: row_pat = {2'b10, 7'h7f, 7'b11_1_0000};
        5'h0a: row_pat = {2'b11, 7'h7f, 7'b11_1_0001};
        default: row_pat = 16'h0000;
      endcase
    end
  endfunction

  reg  [15:0] pat;
  wire [6:0]  key;
  integer     i;

  // local receiver bit only matters for the pcs-check rows
  assign key = {msg[7:6], msg[4:0]};

  always @* begin
    permitted = 1'b0;
    rank      = prev_rank;
    pat       = 16'h0000;
    for (i = 10; i >= 0; i = i - 1) begin
      pat = row_pat(leader, i[3:0]);
      if (pat[15] && (i[3:0] >= prev_rank) && ((key & pat[13:7]) == pat[6:0]) &&
          (!pat[14] || msg[5])) begin
        permitted = 1'b1;
        rank      = i[3:0];
      end
    end
  end

endmodule
`default_nettype wire

// ==== rtl/tic_codec.v ====
// training information block codec: builds outgoing blocks, parses incoming ones
// assumes AXI4-Lite master on aclk, bit streams synchronous to aclk
`timescale 1ns/1ns
`default_nettype none
`include "tic_defs.vh"

// Behaviour
// - leader message octet: state, rx ok, allow-transmit, four announce bits.
// - follower layout identical, bit 4 carries timing-locked flag.
// - state code 00 initial, 01 backoff, 10 coefficients, 11 final tuning.
// - send only listed message combinations; ignore unlisted ones on receive.
// - octet 9 high nibble is margin code in half-decibel steps.
// - margin 0001 floor, 1111 ceiling, 0000 unknown.
// - announced transition: ten-bit frame countdown in octet 9/10.
// - coefficient transfer: twelve-bit handshake in octet 9/10.
// - ability octet only in state 01, zero otherwise.
// - ability bit 6 asks partner to bypass its precoder.
// - listed octets and bits are reserved in given modes.
// - vendor octets only when both ends agreed, else zero.
// - coefficient transfer: four coefficients, lowest index in octet 11.
// - groups go 0-3 to 12-15, pairs A, B, C, D.
// - crc16 over octets 5 to 14 appended as last two octets.
// - crc cleared before octet 5, accumulate to 14, then shift out.
// - reserved bits sent as zero and ignored on receive.
// - octets in increasing order, each least significant bit first.
// - octets 1 to 4 are the fixed start delimiter.
module tic_codec (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [7:0]   s_axi_awaddr,
  input  wire         s_axi_awvalid,
  output wire         s_axi_awready,
  input  wire [31:0]  s_axi_wdata,
  input  wire [3:0]   s_axi_wstrb,
  input  wire         s_axi_wvalid,
  output wire         s_axi_wready,
  output reg  [1:0]   s_axi_bresp,
  output reg          s_axi_bvalid,
  input  wire         s_axi_bready,
  input  wire [7:0]   s_axi_araddr,
  input  wire         s_axi_arvalid,
  output wire         s_axi_arready,
  output reg  [31:0]  s_axi_rdata,
  output reg  [1:0]   s_axi_rresp,
  output reg          s_axi_rvalid,
  input  wire         s_axi_rready,
  input  wire         tx_frame_start,
  output reg          tx_bit,
  output reg          tx_bit_valid,
  input  wire         rx_bit,
  input  wire         rx_bit_valid,
  input  wire         rx_frame_start,
  output reg          rx_block_new
);

  function [31:0] wmerge(input [31:0] old, input [31:0] d, input [3:0] be);
    integer k;
    begin
      wmerge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          wmerge[8*k +: 8] = d[8*k +: 8];
        end
      end
    end
  endfunction

  // octets 9..14 (octet 9 low) with reserved parts forced to zero
  function [47:0] fmask(input [7:0] msg, input vend, input [47:0] f);
    reg coeff;
    reg ann;
    begin
      coeff = msg[2];
      ann   = msg[3] | msg[1] | msg[0];
      fmask[7:4] = f[7:4];
      // handshake nibble; count bits; rest zero
      fmask[3:0] = coeff ? f[3:0] : (ann ? {2'b00, f[1:0]} : 4'h0);
      fmask[15:8] = (coeff | ann) ? f[15:8] : 8'h00;
      fmask[23:16] = coeff ? f[23:16] : 8'h00;
      // ability octet only in backoff state, low five bits reserved
      fmask[31:24] = coeff ? f[31:24] :
                     (msg[7:6] == `TIC_ST_BACKOFF) ? {f[31:29], 5'b00000} : 8'h00;
      fmask[47:32] = (coeff | vend) ? f[47:32] : 16'h0000;
    end
  endfunction

  reg  [31:0] ctrl_reg;
  reg  [31:0] txmsg_reg;
  reg  [31:0] txset_reg;
  reg  [31:0] vend_reg;
  reg  [3:0]  stat_reg;
  reg  [3:0]  tx_rank_reg;
  reg  [3:0]  rx_rank_reg;
  reg  [31:0] rxhdr_reg;
  reg  [31:0] rxinfo_reg;
  reg  [15:0] rxvend_reg;
  reg  [31:0] coef_mem [0:15];
  reg  [3:0]  gptr_reg;

  wire        wr_en;
  wire        ctrl_wr;
  wire        restart;
  wire        leader;
  wire        vend_ok;
  wire        loc_ok;

  // write taken only with address and data both present
  assign wr_en         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_en;
  assign s_axi_wready  = wr_en;
  assign s_axi_arready = ~s_axi_rvalid;
  assign ctrl_wr       = wr_en && s_axi_awaddr == `TIC_A_CTRL && s_axi_wstrb[0];
  assign restart       = ctrl_wr & s_axi_wdata[`TIC_C_RESTART];
  assign leader        = ctrl_reg[`TIC_C_LEADER];
  assign vend_ok       = ctrl_reg[`TIC_C_VEND];
  assign loc_ok        = ctrl_reg[`TIC_C_LOCOK];

  reg  [3:0]  st_set;
  reg  [3:0]  st_clr;
  reg         wr_hit;

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg     <= 32'h0000_0000;
      txmsg_reg    <= {20'h00000, `TIC_MARGIN_UNKNOWN, 8'h00};
      txset_reg    <= 32'h0000_0000;
      vend_reg     <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TIC_RESP_OK;
    end else begin
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `TIC_RESP_OK : `TIC_RESP_ERR;
        case (s_axi_awaddr)
          // restart and next-group are pulses, not stored
          `TIC_A_CTRL:  ctrl_reg  <= wmerge(ctrl_reg, s_axi_wdata & 32'h0000_000f,
                                            s_axi_wstrb);
          `TIC_A_TXMSG: txmsg_reg <= wmerge(txmsg_reg, s_axi_wdata, s_axi_wstrb);
          `TIC_A_TXSET: txset_reg <= wmerge(txset_reg, s_axi_wdata, s_axi_wstrb);
          `TIC_A_VEND:  vend_reg  <= wmerge(vend_reg, s_axi_wdata, s_axi_wstrb);
          default:      ctrl_reg  <= ctrl_reg;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @* begin
    case (s_axi_awaddr)
      `TIC_A_CTRL, `TIC_A_TXMSG, `TIC_A_TXSET, `TIC_A_VEND, `TIC_A_STAT:
        wr_hit = 1'b1;
      default: wr_hit = (s_axi_awaddr[7:6] == `TIC_A_COEF_TAG);
    endcase
  end

  // coefficient store, one group of four per word
  always @(posedge aclk) begin
    if (wr_en && s_axi_awaddr[7:6] == `TIC_A_COEF_TAG) begin
      coef_mem[s_axi_awaddr[5:2]] <= wmerge(coef_mem[s_axi_awaddr[5:2]], s_axi_wdata,
                                            s_axi_wstrb);
    end
  end

  // group pointer: low two bits group, high two bits pair
  always @(posedge aclk) begin
    if (!aresetn || restart) begin
      gptr_reg <= 4'h0;
    end else if (ctrl_wr && s_axi_wdata[`TIC_C_NEXTGRP]) begin
      gptr_reg <= gptr_reg + 4'h1;
    end
  end

  // read side
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `TIC_RESP_OK;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `TIC_RESP_OK;
      case (s_axi_araddr)
        `TIC_A_CTRL:   s_axi_rdata <= ctrl_reg;
        `TIC_A_TXMSG:  s_axi_rdata <= txmsg_reg;
        `TIC_A_TXSET:  s_axi_rdata <= txset_reg;
        `TIC_A_VEND:   s_axi_rdata <= vend_reg;
        `TIC_A_STAT:   s_axi_rdata <= {20'h00000, stat_reg, rx_rank_reg, tx_rank_reg};
        `TIC_A_RXHDR:  s_axi_rdata <= rxhdr_reg;
        `TIC_A_RXINFO: s_axi_rdata <= rxinfo_reg;
        `TIC_A_RXVEND: s_axi_rdata <= {16'h0000, rxvend_reg};
        default: begin
          if (s_axi_araddr[7:6] == `TIC_A_COEF_TAG) begin
            s_axi_rdata <= coef_mem[s_axi_araddr[5:2]];
          end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TIC_RESP_ERR;
          end
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // transmit path
  reg  [111:0] tx_sh_reg;
  reg  [6:0]   tx_cnt_reg;
  reg          tx_busy_reg;
  reg          tx_first_reg;
  reg  [7:0]   tx_msg_reg;
  wire [7:0]   tx_req;
  wire         tx_ok;
  wire [3:0]   tx_rank_new;
  wire         tx_load;
  wire         tx_crc_msb;
  wire         tx_gen;
  wire         tx_out;
  reg  [7:0]   tx_use;
  reg  [47:0]  tx_f;
  wire [47:0]  tx_fm;
  wire [1:0]   pair_code;
  wire [1:0]   grp_code;

  // bit 5 from local receiver status
  assign tx_req  = {txmsg_reg[7:6], loc_ok, txmsg_reg[4:0]};
  assign tx_load = tx_frame_start & ~tx_busy_reg & ctrl_reg[`TIC_C_EN];
  // codes 01,10,11,00 for index 0..3
  assign pair_code = gptr_reg[3:2] + 2'b01;
  assign grp_code  = gptr_reg[1:0] + 2'b01;

  tic_msg_check u_tx_check (
    .leader    (leader),
    .msg       (tx_req),
    .prev_rank (tx_rank_reg),
    .permitted (tx_ok),
    .rank      (tx_rank_new)
  );

  always @* begin
    // first block sends a zero message octet; refused request repeats last
    if (tx_first_reg) begin
      tx_use = 8'h00;
    end else if (tx_ok) begin
      tx_use = tx_req;
    end else begin
      tx_use = {tx_msg_reg[7:6], loc_ok, tx_msg_reg[4:0]};
    end
    // message octet drives the layout below
    if (tx_use[2]) begin
      // lowest coefficient index sits in the low byte
      tx_f = {coef_mem[gptr_reg], txmsg_reg[19:16], pair_code, grp_code,
              txmsg_reg[11:8], txmsg_reg[23:20]};
    end else begin
      // ability bits eee, bypass request, fast retrain
      tx_f = {vend_reg[15:0], txset_reg[26:24], 5'b00000, 8'h00,
              txmsg_reg[19:12], txmsg_reg[11:8], 2'b00, txmsg_reg[21:20]};
    end
  end

  assign tx_fm = fmask(tx_use, vend_ok, tx_f);

  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_sh_reg    <= 112'h0;
      tx_cnt_reg   <= 7'd0;
      tx_busy_reg  <= 1'b0;
      tx_bit       <= 1'b0;
      tx_bit_valid <= 1'b0;
    end else if (tx_load) begin
      tx_sh_reg   <= {tx_fm, tx_use, txset_reg[23:16] & `TIC_OCT_RSVD,
                      txset_reg[15:8] & `TIC_OCT_RSVD, txset_reg[7:0] & `TIC_OCT_RSVD,
                      `TIC_SFD};
      tx_cnt_reg   <= 7'd0;
      tx_busy_reg  <= 1'b1;
      tx_bit_valid <= 1'b0;
    end else if (tx_busy_reg) begin
      // low bit of the lowest octet leaves first
      tx_sh_reg    <= {1'b0, tx_sh_reg[111:1]};
      tx_bit       <= tx_out;
      tx_bit_valid <= 1'b1;
      tx_cnt_reg   <= tx_cnt_reg + 7'd1;
      tx_busy_reg  <= tx_cnt_reg != `TIC_LAST_BIT;
    end else begin
      tx_bit       <= 1'b0;
      tx_bit_valid <= 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn || restart) begin
      tx_first_reg <= 1'b1;
      tx_msg_reg   <= 8'h00;
      tx_rank_reg  <= 4'h0;
    end else if (tx_load) begin
      tx_first_reg <= 1'b0;
      tx_msg_reg   <= tx_use;
      if (!tx_first_reg && tx_ok) begin
        tx_rank_reg <= tx_rank_new;
      end
    end
  end

  // serial bits of octets 5..14 feed the crc
  assign tx_gen = tx_busy_reg && tx_cnt_reg >= `TIC_CRC_FIRST && tx_cnt_reg <= `TIC_CRC_LAST;
  assign tx_out = (tx_cnt_reg >= `TIC_CRC_OUT) ? tx_crc_msb : tx_sh_reg[0];

  tic_crc16 u_tx_crc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (tx_load),
    .gen     (tx_gen),
    .shift   (tx_busy_reg && tx_cnt_reg >= `TIC_CRC_OUT),
    .din     (tx_sh_reg[0]),
    .msb     (tx_crc_msb)
  );

  // receive path
  reg  [127:0] rx_sh_reg;
  reg  [6:0]   rx_cnt_reg;
  reg          rx_act_reg;
  reg          rx_bad_reg;
  wire [127:0] rx_full;
  wire         rx_take;
  wire         rx_last;
  wire         rx_gen;
  wire         rx_cmp;
  wire         rx_miss;
  wire         rx_crc_msb;
  wire         rx_ok;
  wire [3:0]   rx_rank_new;
  wire         rx_good;
  wire [47:0]  rx_fm = fmask(rx_full[63:56], vend_ok, rx_full[111:64]);

  assign rx_take = rx_bit_valid & (rx_act_reg | rx_frame_start);
  assign rx_full = {rx_bit, rx_sh_reg[127:1]};
  assign rx_gen  = rx_bit_valid && rx_act_reg && !rx_frame_start &&
                   rx_cnt_reg >= `TIC_CRC_FIRST && rx_cnt_reg <= `TIC_CRC_LAST;
  assign rx_cmp  = rx_bit_valid && rx_act_reg && !rx_frame_start &&
                   rx_cnt_reg >= `TIC_CRC_OUT;
  assign rx_miss = rx_cmp & (rx_bit ^ rx_crc_msb);
  assign rx_last = rx_cmp && rx_cnt_reg == `TIC_LAST_BIT;
  // delimiter and crc must both match
  assign rx_good = (rx_full[31:0] == `TIC_SFD) & ~rx_bad_reg & ~rx_miss;

  tic_crc16 u_rx_crc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (rx_bit_valid & rx_frame_start),
    .gen     (rx_gen),
    .shift   (rx_cmp),
    .din     (rx_bit),
    .msb     (rx_crc_msb)
  );

  // partner holds the opposite role
  tic_msg_check u_rx_check (
    .leader    (~leader),
    .msg       (rx_full[63:56]),
    .prev_rank (rx_rank_reg),
    .permitted (rx_ok),
    .rank      (rx_rank_new)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_sh_reg  <= 128'h0;
      rx_cnt_reg <= 7'd0;
      rx_act_reg <= 1'b0;
      rx_bad_reg <= 1'b0;
    end else if (rx_take) begin
      rx_sh_reg  <= rx_full;
      rx_cnt_reg <= rx_frame_start ? 7'd1 : rx_cnt_reg + 7'd1;
      rx_act_reg <= rx_frame_start | ~rx_last;
      rx_bad_reg <= ~rx_frame_start & (rx_bad_reg | rx_miss);
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rxhdr_reg    <= 32'h0000_0000;
      rxinfo_reg   <= 32'h0000_0000;
      rxvend_reg   <= 16'h0000;
      rx_rank_reg  <= 4'h0;
      rx_block_new <= 1'b0;
    end else begin
      rx_block_new <= rx_last & rx_good & rx_ok;
      if (restart) begin
        rx_rank_reg <= 4'h0;
      end else if (rx_last && rx_good && rx_ok) begin
        // reserved parts of octets 9..14 dropped before software sees them
        rxhdr_reg   <= rx_full[63:32];
        rxinfo_reg  <= rx_fm[31:0];
        rxvend_reg  <= rx_fm[47:32];
        rx_rank_reg <= rx_rank_new;
      end
    end
  end

  // sticky status: hardware set beats software clear
  always @* begin
    st_set = {rx_last & rx_good & rx_ok, rx_last & rx_good & ~rx_ok,
              rx_last & ~rx_good, tx_load & ~tx_first_reg & ~tx_ok};
    st_clr = (wr_en && s_axi_awaddr == `TIC_A_STAT && s_axi_wstrb[1]) ?
             s_axi_wdata[`TIC_S_RXNEW:`TIC_S_REFUSED] : 4'h0;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      stat_reg <= 4'h0;
    end else begin
      stat_reg <= (stat_reg & ~st_clr) | st_set;
    end
  end

endmodule
`default_nettype wire

// ==== testbench/tic_codec_checker.sv ====
// port assertions for the training block codec
// bound to tic_codec; single aclk domain
`timescale 1ns/1ns
`default_nettype none
module tic_codec_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        tx_frame_start,
  input wire logic        tx_bit,
  input wire logic        tx_bit_valid,
  input wire logic        rx_bit_valid,
  input wire logic        rx_frame_start,
  input wire logic        rx_block_new
);
  logic [7:0]  n;
  logic [7:0]  r;
  logic [15:0] c;
  logic        first;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // n is the index of the bit on tx_bit
  always @(posedge aclk) begin
    n <= (!aresetn || !tx_bit_valid) ? 8'h00 : n + 8'h01;
    first <= !aresetn ? 1'b1 : (n == 8'h7f) ? 1'b0 : first;
    if (!aresetn)
      r <= 8'h00;
    else if (rx_bit_valid)
      r <= rx_frame_start ? 8'h01 : r + 8'h01;
    if (n == 8'h00)
      c <= 16'h0000;
    else if (tx_bit_valid && n >= 8'h20 && n < 8'h70)
      c <= {c[14:0], 1'b0} ^ ((c[15] ^ tx_bit) ? 16'h8005 : 16'h0000);
  end
  sequence oct1_s;
    tx_bit [*2] ##1 !tx_bit ##1 tx_bit [*3] ##1 !tx_bit ##1 tx_bit;
  endsequence
  sequence oct2_s;
    tx_bit [*3] ##1 (!tx_bit) [*2] ##1 tx_bit ##1 !tx_bit ##1 tx_bit;
  endsequence
  sequence zero_s;
    (!tx_bit) [*8] ##1 (!tx_bit) [*8];
  endsequence
  sfd_order_a: assert property (
    $rose(tx_bit_valid) |-> oct1_s ##1 oct2_s ##1 zero_s) else $error("bad delimiter");
  crc_tail_a: assert property (
    tx_bit_valid && n >= 8'h70 |-> tx_bit == c[4'hf - n[3:0]]) else $error("bad crc bit");
  frame_len_a: assert property (
    $fell(tx_bit_valid) |-> n == 8'h80) else $error("block length not 128");
  start_lat_a: assert property (
    $rose(tx_bit_valid) |-> $past(tx_frame_start, 2)) else $error("block without start");
  rsvd_zero_a: assert property (
    tx_bit_valid && n >= 8'h20 && n < 8'h38 && !n[2] |-> !tx_bit) else $error("reserved set");
  first_msg_a: assert property (
    tx_bit_valid && first && n[7:3] == 5'd7 |-> !tx_bit) else $error("first message not 0");
  wr_answer_a: assert property (
    s_axi_awvalid && s_axi_awready |=> s_axi_bvalid && !s_axi_awready) else $error("no bvalid");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp dropped");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata dropped");
  rx_accept_a: assert property (
    rx_block_new |-> r == 8'h80 ##1 !rx_block_new) else $error("bad accept pulse");
endmodule
`default_nettype wire

// ==== testbench/tic_partner.sv ====
// link partner model: captures sent blocks, sends blocks to the codec
// driven from the bench by hierarchical task calls on aclk
`timescale 1ns/1ns
`default_nettype none
module tic_partner (
  input  wire logic aclk,
  input  wire logic tx_bit,
  input  wire logic tx_bit_valid,
  output var  logic rx_bit,
  output var  logic rx_bit_valid,
  output var  logic rx_frame_start
);
  logic [127:0] cap;
  logic [7:0]   k;
  int           blocks = 0;
  initial begin
    rx_bit = 1'b0;
    rx_bit_valid = 1'b0;
    rx_frame_start = 1'b0;
    k = 8'h00;
  end
  // octets arrive lsb first in order
  always @(posedge aclk) begin
    k <= tx_bit_valid ? k + 8'h01 : 8'h00;
    if (tx_bit_valid)
      cap[k[6:0]] <= tx_bit;
    if (tx_bit_valid && k == 8'h7f)
      blocks <= blocks + 1;
  end
  // clear, then octets 5-14 lsb first
  // crc high element first, fixed delimiter
  function automatic logic [127:0] mk(input logic [79:0] o);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 0; i < 80; i++)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ o[i]) ? 16'h8005 : 16'h0000);
    for (int j = 0; j < 16; j++)
      mk[112 + j] = c[15 - j];
    mk[111:0] = {o, 32'h0000a7bb};
  endfunction
  // released line shows the inverse of its last bit
  task automatic send(input logic [127:0] v);
    for (int i = 0; i < 128; i++) begin
      @(posedge aclk);
      rx_bit <= v[i];
      rx_bit_valid <= 1'b1;
      rx_frame_start <= (i == 0);
    end
    @(posedge aclk);
    rx_bit <= ~v[127];
    rx_bit_valid <= 1'b0;
    rx_frame_start <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== testbench/test_tic_codec.sv ====
// bench for tic_codec: AXI4-Lite tasks, partner model on the bit streams
// assumes tic_partner and tic_codec_checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module test_tic_codec;
  logic         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic         s_axi_rready, tx_frame_start;
  logic [7:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, rd;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   rs;
  logic [127:0] v, e3, good;
  logic [7:0]   bad [2] = '{8'h50, 8'h0f};
  int           errors = 0, compares = 0, b;
  wire          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire          tx_bit, tx_bit_valid, rx_bit, rx_bit_valid, rx_frame_start, rx_block_new;
  wire [1:0]    s_axi_bresp, s_axi_rresp;
  wire [31:0]   s_axi_rdata;
  tic_codec uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .tx_frame_start, .tx_bit, .tx_bit_valid, .rx_bit, .rx_bit_valid,
    .rx_frame_start, .rx_block_new);
  tic_partner p (.aclk, .tx_bit, .tx_bit_valid, .rx_bit, .rx_bit_valid, .rx_frame_start);
  task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] want);
    compares++;
    if (seen !== want) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask
  // ready and valid are sampled at the rising edge that takes them
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m, want);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(what, rd & m, want);
  endtask
  task automatic txf(output logic [127:0] f);
    b = p.blocks;
    @(posedge aclk);
    tx_frame_start <= 1'b1;
    @(posedge aclk);
    tx_frame_start <= 1'b0;
    wait (p.blocks == b + 1);
    f = p.cap;
  endtask
  task automatic give_verdict;
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    #200000;
    errors++;
    give_verdict();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
    {s_axi_rready, tx_frame_start, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("ctrl_reset", 8'h00, 32'hffffffff, 32'h0);
    rchk("txmsg_reset", 8'h04, 32'hffffffff, 32'h0);
    rchk("stat_reset", 8'h10, 32'hffffffff, 32'h0);
    rchk("rd_unmapped", 8'h30, 32'hffffffff, 32'h0);
    chk("rresp_unmapped", rs, 2'b10);
    wr(8'h30, 32'h1);
    chk("bresp_unmapped", rs, 2'b10);
    wr(8'h08, 32'h070000a7);
    wr(8'h04, 32'h00155550);
    wr(8'h0c, 32'h0000beef);
    wr(8'h00, 32'h3);
    txf(v);
    chk("tx_first", v, p.mk(80'h0000_0000_0050_0000_00a0));
    wr(8'h00, 32'hf);
    txf(v);
    chk("tx_backoff", v, p.mk(80'hbeef_e000_0050_7000_00a0));
    wr(8'h04, 32'h00155f58);
    txf(v);
    e3 = p.mk(80'hbeef_e000_55f1_7800_00a0);
    chk("tx_count", v, e3);
    foreach (bad[i]) begin
      wr(8'h04, {24'h00155f, bad[i]});
      txf(v);
      chk("tx_refused", v, e3);
      rchk("stat_refused", 8'h10, 32'h100, 32'h100);
      wr(8'h10, 32'h100);
    end
    wr(8'h40, 32'h44332211);
    wr(8'h04, 32'h00050f94);
    txf(v);
    chk("tx_coef", v, p.mk(80'h4433_2211_55f0_b400_00a0));
    good = p.mk(80'h0000_0000_0000_5000_0090);
    p.send(good);
    rchk("stat_rx_new", 8'h10, 32'h800, 32'h800);
    rchk("rx_hdr", 8'h14, 32'hffffffff, 32'h50000090);
    p.send(p.mk(80'h0000_0000_0000_5000_00a0) ^ (128'h1 << 120));
    rchk("stat_crc", 8'h10, 32'h200, 32'h200);
    rchk("rx_hdr_kept", 8'h14, 32'hffffffff, 32'h50000090);
    p.send(p.mk(80'h0000_0000_0000_0f00_00b0));
    rchk("stat_ignored", 8'h10, 32'h400, 32'h400);
    rchk("rx_hdr_same", 8'h14, 32'hffffffff, 32'h50000090);
    s_axi_wstrb <= 4'h2;
    wr(8'h0c, 32'h00005a00);
    rchk("vend_strobe", 8'h0c, 32'hffffffff, 32'h00005aef);
    give_verdict();
  end
endmodule
bind tic_codec tic_codec_checker chk_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .tx_frame_start, .tx_bit, .tx_bit_valid, .rx_bit_valid,
  .rx_frame_start, .rx_block_new);
`default_nettype wire
